/* File: core/nand_host.sv */
// nand flash host sequencer with its read data fifo
`timescale 1ns/10ps
module nand_host_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_valid,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_ready,
	output logic o_valid,
	output logic [WIDTH-1:0] o_data,
	input wire logic i_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic push;
	logic pop;
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	assign o_data = mem_q[rd_q];
	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_data;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			o_valid <= 1'b0;
			o_ready <= 1'b0;
		end else begin
			wr_q <= push ? AW'(wr_q + 1'b1) : wr_q;
			rd_q <= pop ? AW'(rd_q + 1'b1) : rd_q;
			cnt_q <= cnt_d;
			o_valid <= cnt_d != '0;
			o_ready <= cnt_d != (AW+1)'(DEPTH);
		end
	end
endmodule : nand_host_fifo

module nand_host
	import nand_host_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_start,
	input wire req_t i_req,
	output logic o_busy,
	output logic o_done,
	output logic o_refused,
	output logic o_fail,
	output logic [7:0] o_status,
	output logic o_ctrl_ready,
	output logic o_cache_ready,
	input wire logic i_wr_valid,
	input wire logic [DATA_W-1:0] i_wr_data,
	output logic o_wr_ready,
	output logic o_rd_valid,
	output logic [DATA_W-1:0] o_rd_data,
	input wire logic i_rd_ready,
	output logic o_ce_n,
	output logic o_cle,
	output logic o_ale,
	output logic o_we_n,
	output logic o_re_n,
	output logic o_wp_n,
	output logic [7:0] o_io_out,
	output logic o_io_oe,
	input wire logic [7:0] i_io_in,
	input wire logic i_ready_busy
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0, ST_CMD1 = 4'h1, ST_ADDR = 4'h2, ST_DIN = 4'h3, ST_CMD2 = 4'h4, ST_WB = 4'h5,
		ST_BUSY = 4'h6, ST_DOUT = 4'h7, ST_STCMD = 4'h8, ST_STRD = 4'h9, ST_DONE = 4'hA
	} state_t;
	typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_LOW = 2'h1, PH_HIGH = 2'h2} phase_t;
	state_t state_q;
	phase_t phase_q;
	req_t req_q;
	plan_t plan;
	logic [3:0] tmr_q;
	logic [3:0] wcnt_q;
	logic [2:0] idx_q;
	logic [11:0] cnt_q;
	logic rb_s1_q, rb_s2_q;
	logic [7:0] io_s1_q, io_s2_q;
	logic push_q;
	logic [7:0] rd_byte_q;
	logic fifo_ready;
	logic cyc_go, cyc_end, is_read, refuse, accept;
	logic cache_q, page_open_q, loading_q, loaded_q, copy_src_q, src_top_q;
	logic [16:0] part_row_q;
	logic [2:0] part_cnt_q;
	state_t nx_a, nx_b, nx_c, nx_d, nx_e;
	logic [7:0] wbyte;
	logic wcle, wale;

	function automatic plan_t plan_of(op_t op);
		plan_t p;
		p = '0;
		unique case (op)
			OP_READ: p = '{CMD_READ, CMD_READ_GO, 1'b1, ADDR_FULL, 1'b0, 1'b1, 1'b1, 1'b0};
			OP_CACHE_READ: p = '{CMD_READ, CMD_CACHE_GO, 1'b1, ADDR_FULL, 1'b0, 1'b1, 1'b1, 1'b0};
			OP_CACHE_EXIT: p = '{CMD_CACHE_EXIT, 8'h00, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1, 1'b0};
			OP_RAND_OUT: p = '{CMD_RAND_OUT, CMD_RAND_OUT_GO, 1'b1, ADDR_COL, 1'b0, 1'b1, 1'b0, 1'b0};
			OP_PROG_LOAD: p = '{CMD_PROG, 8'h00, 1'b0, ADDR_FULL, 1'b1, 1'b0, 1'b0, 1'b0};
			OP_RAND_IN: p = '{CMD_RAND_IN, 8'h00, 1'b0, ADDR_COL, 1'b1, 1'b0, 1'b0, 1'b0};
			OP_PROG_GO: p = '{CMD_PROG_GO, 8'h00, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1, 1'b1};
			OP_COPY_READ: p = '{CMD_READ, CMD_COPY_GO, 1'b1, ADDR_FULL, 1'b0, 1'b0, 1'b1, 1'b0};
			OP_COPY_LOAD: p = '{CMD_RAND_IN, 8'h00, 1'b0, ADDR_FULL, 1'b1, 1'b0, 1'b0, 1'b0};
			default: p = '0;
		endcase
		return p;
	endfunction : plan_of

	assign plan = plan_of(req_q.op);
	assign nx_e = plan.status ? ST_STCMD : ST_DONE;
	assign nx_d = plan.dout ? ST_DOUT : nx_e;
	assign nx_c = plan.wait_rb ? ST_WB : nx_d;
	assign nx_b = plan.has_cmd2 ? ST_CMD2 : nx_c;
	assign nx_a = (plan.din && req_q.len != 12'h000) ? ST_DIN : nx_b;
	assign is_read = state_q == ST_DOUT || state_q == ST_STRD;
	assign cyc_end = phase_q == PH_HIGH && tmr_q == 4'h0;

	// address bytes: column low, column high, then page and block
	always_comb begin
		wbyte = 8'h00;
		wcle = 1'b0;
		wale = 1'b0;
		unique case (state_q)
			ST_CMD1: begin
				wbyte = plan.cmd1;
				wcle = 1'b1;
			end
			ST_CMD2: begin
				wbyte = plan.cmd2;
				wcle = 1'b1;
			end
			ST_STCMD: begin
				wbyte = CMD_STATUS;
				wcle = 1'b1;
			end
			ST_ADDR: begin
				wale = 1'b1;
				unique case (idx_q)
					3'h0: wbyte = req_q.addr[7:0];
					3'h1: wbyte = {4'h0, req_q.addr[11:8]};
					3'h2: wbyte = req_q.addr[19:12];
					3'h3: wbyte = req_q.addr[27:20];
					default: wbyte = {7'h00, req_q.addr[28]};
				endcase
			end
			ST_DIN: wbyte = i_wr_data;
			default: wbyte = 8'h00;
		endcase
	end

	always_comb begin
		cyc_go = 1'b0;
		if (phase_q == PH_IDLE) begin
			unique case (state_q)
				ST_CMD1, ST_CMD2, ST_ADDR, ST_STCMD, ST_STRD: cyc_go = 1'b1;
				ST_DIN: cyc_go = o_wr_ready && i_wr_valid;
				ST_DOUT: cyc_go = fifo_ready && !push_q;
				default: cyc_go = 1'b0;
			endcase
		end
	end

	always_comb begin
		unique case (i_req.op)
			OP_CACHE_READ: refuse = i_req.addr[11:0] != 12'h000;
			OP_RAND_OUT: refuse = cache_q || !page_open_q;
			OP_PROG_LOAD: refuse = i_req.len == 12'h000 || i_req.len > PAGE_BYTES ||
				(i_req.addr[28:12] == part_row_q && part_cnt_q == PARTIAL_MAX);
			OP_RAND_IN: refuse = !loading_q || i_req.len == 12'h000 || i_req.len > PAGE_BYTES;
			OP_PROG_GO: refuse = !loaded_q;
			OP_COPY_LOAD: refuse = !copy_src_q || i_req.len > PAGE_BYTES ||
				i_req.addr[TOP_BIT] != src_top_q;
			default: refuse = 1'b0;
		endcase
	end
	assign accept = state_q == ST_IDLE && i_start && !refuse;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rb_s1_q <= 1'b0;
			rb_s2_q <= 1'b0;
			io_s1_q <= 8'h00;
			io_s2_q <= 8'h00;
		end else begin
			rb_s1_q <= i_ready_busy;
			rb_s2_q <= rb_s1_q;
			io_s1_q <= i_io_in;
			io_s2_q <= io_s1_q;
		end
	end

	// pin strobe engine: one bus cycle per cyc_go
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			phase_q <= PH_IDLE;
			tmr_q <= 4'h0;
			o_cle <= 1'b0;
			o_ale <= 1'b0;
			o_we_n <= 1'b1;
			o_re_n <= 1'b1;
			o_io_out <= 8'h00;
			o_io_oe <= 1'b0;
			o_wp_n <= 1'b0;
			push_q <= 1'b0;
			rd_byte_q <= 8'h00;
		end else begin
			o_wp_n <= 1'b1;
			push_q <= 1'b0;
			unique case (phase_q)
				PH_IDLE: if (cyc_go) begin
					phase_q <= PH_LOW;
					o_cle <= wcle;
					o_ale <= wale;
					o_io_out <= wbyte;
					o_io_oe <= !is_read;
					o_we_n <= is_read;
					o_re_n <= !is_read;
					tmr_q <= is_read ? 4'(RE_CYC - 1) : 4'(PULSE_CYC - 1);
				end
				PH_LOW: if (tmr_q == 4'h0) begin
					o_we_n <= 1'b1;
					o_re_n <= 1'b1;
					if (is_read) begin
						rd_byte_q <= io_s2_q;
						push_q <= state_q == ST_DOUT;
					end
					phase_q <= PH_HIGH;
					tmr_q <= 4'(HOLD_CYC - 1);
				end else begin
					tmr_q <= tmr_q - 4'h1;
				end
				PH_HIGH: if (tmr_q == 4'h0) begin
					phase_q <= PH_IDLE;
					o_cle <= 1'b0;
					o_ale <= 1'b0;
					o_io_oe <= 1'b0;
				end else begin
					tmr_q <= tmr_q - 4'h1;
				end
				default: phase_q <= PH_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_wr_ready <= 1'b0;
		end else begin
			o_wr_ready <= state_q == ST_DIN && phase_q == PH_IDLE && !(o_wr_ready && i_wr_valid);
		end
	end

	// sequence walker
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			req_q <= '0;
			idx_q <= 3'h0;
			cnt_q <= 12'h000;
			wcnt_q <= 4'h0;
			o_ce_n <= 1'b1;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_refused <= 1'b0;
		end else begin
			o_done <= 1'b0;
			o_refused <= state_q == ST_IDLE && i_start && refuse;
			unique case (state_q)
				ST_IDLE: if (accept) begin
					req_q <= i_req;
					idx_q <= 3'h0;
					cnt_q <= 12'h000;
					o_ce_n <= 1'b0;
					o_busy <= 1'b1;
					state_q <= i_req.op == OP_STATUS ? ST_STCMD : ST_CMD1;
				end
				ST_CMD1: if (cyc_end) begin
					state_q <= plan.naddr != 3'h0 ? ST_ADDR : nx_a;
				end
				ST_ADDR: if (cyc_end) begin
					idx_q <= idx_q + 3'h1;
					if (idx_q == plan.naddr - 3'h1) begin
						state_q <= nx_a;
					end
				end
				ST_DIN: if (cyc_end) begin
					cnt_q <= cnt_q + 12'h001;
					if (cnt_q == req_q.len - 12'h001) begin
						cnt_q <= 12'h000;
						state_q <= nx_b;
					end
				end
				ST_CMD2: if (cyc_end) begin
					state_q <= nx_c;
					wcnt_q <= 4'h0;
				end
				ST_WB: begin
					wcnt_q <= wcnt_q + 4'h1;
					if (wcnt_q == 4'(WB_CYC - 1)) begin
						state_q <= ST_BUSY;
					end
				end
				ST_BUSY: if (rb_s2_q) begin
					state_q <= nx_d;
				end
				ST_DOUT: if (cyc_end) begin
					cnt_q <= cnt_q + 12'h001;
					if (cnt_q == req_q.len - 12'h001) begin
						state_q <= nx_e;
					end
				end
				ST_STCMD: if (cyc_end) begin
					state_q <= ST_STRD;
				end
				ST_STRD: if (cyc_end) begin
					state_q <= ST_DONE;
				end
				ST_DONE: begin
					o_ce_n <= 1'b1;
					o_busy <= 1'b0;
					o_done <= 1'b1;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// device mode tracking and status
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cache_q <= 1'b0;
			page_open_q <= 1'b0;
			loading_q <= 1'b0;
			loaded_q <= 1'b0;
			copy_src_q <= 1'b0;
			src_top_q <= 1'b0;
			part_row_q <= 17'h00000;
			part_cnt_q <= 3'h0;
		end else if (accept) begin
			unique case (i_req.op)
				OP_READ: begin
					page_open_q <= 1'b1;
					cache_q <= 1'b0;
				end
				OP_CACHE_READ: begin
					page_open_q <= 1'b1;
					cache_q <= 1'b1;
				end
				OP_CACHE_EXIT: begin
					cache_q <= 1'b0;
					page_open_q <= 1'b0;
				end
				OP_PROG_LOAD: begin
					loading_q <= 1'b1;
					loaded_q <= 1'b1;
					copy_src_q <= 1'b0;
					page_open_q <= 1'b0;
					part_row_q <= i_req.addr[28:12];
					part_cnt_q <= i_req.addr[28:12] == part_row_q ? part_cnt_q + 3'h1 : 3'h1;
				end
				OP_COPY_READ: begin
					copy_src_q <= 1'b1;
					src_top_q <= i_req.addr[TOP_BIT];
					page_open_q <= 1'b0;
				end
				OP_COPY_LOAD: begin
					loading_q <= 1'b1;
					loaded_q <= 1'b1;
				end
				OP_PROG_GO, OP_STATUS: begin
					loading_q <= 1'b0;
					loaded_q <= 1'b0;
					copy_src_q <= 1'b0;
					page_open_q <= 1'b0;
				end
				default: loading_q <= loading_q;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_status <= 8'h00;
			o_fail <= 1'b0;
			o_ctrl_ready <= 1'b0;
			o_cache_ready <= 1'b0;
		end else if (state_q == ST_STRD && cyc_end) begin
			o_status <= rd_byte_q;
			o_fail <= plan.status && rd_byte_q[ST_FAIL_BIT];
			o_ctrl_ready <= rd_byte_q[ST_CTRL_BIT];
			o_cache_ready <= rd_byte_q[ST_CACHE_BIT];
		end
	end

	nand_host_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_valid(push_q),
		.i_data(rd_byte_q),
		.o_ready(fifo_ready),
		.o_valid(o_rd_valid),
		.o_data(o_rd_data),
		.i_ready(i_rd_ready)
	);

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	sequence we_low_pulse;
		!o_we_n[*4] ##1 o_we_n;
	endsequence
	sequence refused_next;
		##1 o_refused && state_q == ST_IDLE;
	endsequence
	cmd_latch_a: assert property ($fell(o_we_n) && o_cle |-> ((o_io_oe && !o_ale) and we_low_pulse))
		else $error("command cycle malformed");
	cache_col_a: assert property (state_q == ST_IDLE && i_start && i_req.op == OP_CACHE_READ &&
		i_req.addr[11:0] != 12'h000 |-> refused_next) else $error("cache read column not zero");
	rand_out_a: assert property (state_q == ST_IDLE && i_start && i_req.op == OP_RAND_OUT && cache_q
		|-> refused_next) else $error("random output during cache read");
	partial_max_a: assert property (part_cnt_q <= PARTIAL_MAX) else $error("too many partial programs");
	confirm_loaded_a: assert property (state_q == ST_IDLE && i_start && i_req.op == OP_PROG_GO && !loaded_q
		|-> refused_next) else $error("program confirm without data");
	copy_top_a: assert property (state_q == ST_IDLE && i_start && i_req.op == OP_COPY_LOAD &&
		i_req.addr[TOP_BIT] != src_top_q |-> refused_next) else $error("copy back top bit differs");
	busy_hold_a: assert property (state_q == ST_BUSY && !rb_s2_q |=> state_q == ST_BUSY)
		else $error("left busy wait early");
	prog_status_a: assert property (state_q == ST_BUSY && rb_s2_q && plan.status |=> state_q == ST_STCMD)
		else $error("no status read after program");
	confirm_wait_a: assert property (state_q == ST_CMD2 && cyc_end && plan.wait_rb |=>
		state_q == ST_WB ##12 state_q == ST_WB ##1 state_q == ST_BUSY) else $error("busy sample too early");
endmodule : nand_host

/* File: pkg/nand_host_pkg.sv */
// constants and types of the nand flash host sequencer
// Functional notes
// - Each read enable pulse returns the next byte from the selected column onward.
// - Cache read is setup, four or five address cycles, then cache confirm.
// - Cache read start column must be zero; host refuses any other column.
// - Cache read ends only by the exit cache read command; host also drops its cache mode on a plain page read.
// - At most four partial programs per page before erase; host refuses a fifth load only if no other page was loaded in between.
// - Program is setup, address cycles, data, confirm; confirm only after data load.
// - Random data input redirects loading with two column address cycles, repeatable.
// - Copy back source read is setup, address cycles, confirm; whole page buffered.
// - After ready, host sends copy program, target address, optional data, confirm.
// - Source and target keep the same top block address bit.
// - Host should program pages in order and limit repeated copy back.
// - Commands go on the low byte, latched at write enable rise with command latch high.
// - Read 00h/30h, cache 31h, random output 05h/E0h, exit cache 34h.
// - Program 80h/10h, random input 85h, copy back 00h/35h then 85h/10h.
package nand_host_pkg;
	localparam int CLK_NS = 8;
	localparam int PULSE_NS = 25;
	localparam int HOLD_NS = 15;
	localparam int RE_NS = 40;
	localparam int WB_NS = 100;
	localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RE_CYC = (RE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WB_CYC = (WB_NS + CLK_NS - 1) / CLK_NS;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam logic [11:0] PAGE_BYTES = 12'h840;
	localparam logic [2:0] PARTIAL_MAX = 3'h4;
	localparam logic [2:0] ADDR_FULL = 3'h5;
	localparam logic [2:0] ADDR_COL = 3'h2;
	localparam int TOP_BIT = 28;
	localparam int ST_FAIL_BIT = 0;
	localparam int ST_CTRL_BIT = 5;
	localparam int ST_CACHE_BIT = 6;
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_READ_GO = 8'h30;
	localparam logic [7:0] CMD_CACHE_GO = 8'h31;
	localparam logic [7:0] CMD_CACHE_EXIT = 8'h34;
	localparam logic [7:0] CMD_RAND_OUT = 8'h05;
	localparam logic [7:0] CMD_RAND_OUT_GO = 8'hE0;
	localparam logic [7:0] CMD_PROG = 8'h80;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_RAND_IN = 8'h85;
	localparam logic [7:0] CMD_COPY_GO = 8'h35;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	typedef enum logic [3:0] {
		OP_READ = 4'h0, OP_CACHE_READ = 4'h1, OP_CACHE_EXIT = 4'h2, OP_RAND_OUT = 4'h3,
		OP_PROG_LOAD = 4'h4, OP_RAND_IN = 4'h5, OP_PROG_GO = 4'h6, OP_COPY_READ = 4'h7,
		OP_COPY_LOAD = 4'h8, OP_STATUS = 4'h9
	} op_t;
	typedef struct packed {
		op_t op;
		logic [28:0] addr;
		logic [11:0] len;
	} req_t;
	typedef struct packed {
		logic [7:0] cmd1;
		logic [7:0] cmd2;
		logic has_cmd2;
		logic [2:0] naddr;
		logic din;
		logic dout;
		logic wait_rb;
		logic status;
	} plan_t;
endpackage : nand_host_pkg

/* File: testbench/nand_dev_model.sv */
// behavioural nand flash device answering the host sequencer
`timescale 1ns/10ps
module nand_dev_model #(
	parameter int BUSY_NS = 400
) (
	input wire logic i_ce_n,
	input wire logic i_cle,
	input wire logic i_ale,
	input wire logic i_we_n,
	input wire logic i_re_n,
	input wire logic i_wp_n,
	input wire logic [7:0] i_io_out,
	input wire logic i_io_oe,
	input wire logic i_fail_next,
	output logic [7:0] o_io,
	output logic o_ready_busy
);
	logic [7:0] mem [logic [28:0]];
	logic [7:0] pbuf [0:2111];
	logic [7:0] adr [0:4] = '{default: 8'h00};
	logic [7:0] dout_q = 8'h00;
	logic [7:0] last_q = 8'h00;
	logic drv_q = 1'b0;
	logic stat_q = 1'b0; // power-up in array read mode
	logic cache_q = 1'b0;
	logic fail_q = 1'b0;
	logic [16:0] row;
	int acnt = 0;
	int col = 0;
	initial o_ready_busy = 1'b1;
	assign row = {adr[4][0], adr[3], adr[2]};
	task automatic go_busy();
		o_ready_busy = 1'b0; // low while the internal controller works
		o_ready_busy <= #BUSY_NS 1'b1;
	endtask : go_busy
	task automatic load_page();
		for (int i = 0; i < 2112; i++) pbuf[i] = mem.exists({row, i[11:0]}) ? mem[{row, i[11:0]}] : 8'hFF;
		go_busy();
	endtask : load_page
	always @(posedge i_we_n) begin
		if (!i_ce_n && i_cle) begin // command on low byte at write enable rise
			if ((o_ready_busy || i_io_out == 8'h70 || (cache_q && i_io_out == 8'h34)) && // others ignored
				!(cache_q && i_io_out == 8'h05)) begin // random output refused in cache read
				acnt = 0;
				stat_q = 1'b0;
				case (i_io_out)
					8'h30, 8'h35: load_page();
					8'h31: begin
						cache_q = 1'b1;
						load_page(); // ready again after latency
					end
					8'h34: begin
						cache_q = 1'b0;
						go_busy();
					end
					8'h80: for (int i = 0; i < 2112; i++) pbuf[i] = 8'hFF;
					8'h10: begin
						for (int i = 0; i < 2112; i++) mem[{row, i[11:0]}] = pbuf[i] &
							(mem.exists({row, i[11:0]}) ? mem[{row, i[11:0]}] : 8'hFF);
						fail_q = i_fail_next;
						stat_q = 1'b1;
						go_busy();
					end
					8'h70: stat_q = 1'b1;
					default: ;
				endcase
			end
		end else if (!i_ce_n && i_ale) begin
			if (acnt < 5) adr[acnt] = i_io_out; // column bytes first, extra ignored
			acnt++;
			col = {adr[1][3:0], adr[0]};
		end else if (!i_ce_n) begin
			if (col < 2112) pbuf[col] = i_io_out; // any count up to a page
			col++;
		end
	end
	always @(negedge i_re_n) begin
		if (!i_ce_n) begin
			drv_q = 1'b1;
			dout_q = stat_q ? {i_wp_n, o_ready_busy, o_ready_busy, 4'h0, fail_q} :
				(col < 2112 ? pbuf[col] : 8'hFF);
			if (!stat_q) col++; // next column each pulse
		end
	end
	always @(posedge i_re_n) begin
		drv_q = 1'b0;
		last_q = dout_q;
	end
	assign o_io = i_io_oe ? i_io_out : (drv_q ? dout_q : ~last_q);
endmodule : nand_dev_model

/* File: testbench/nand_host_tb_top.sv */
// self-checking bench of the nand host sequencer against a device model
`timescale 1ns/10ps
module nand_host_tb_top
	import nand_host_pkg::*;
;
	localparam logic [28:0] ROW_A = 29'h0001000;
	localparam logic [28:0] ROW_B = 29'h10002000;
	localparam logic [28:0] ROW_C = 29'h0002000;
	localparam logic [28:0] ROW_D = 29'h0003000;
	typedef struct packed {
		op_t op;
		logic [28:0] addr;
		logic [11:0] len;
		logic refused;
	} row_t;
	row_t rows [0:33];
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	req_t req = '0;
	logic wr_valid = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic rd_ready = 1'b0;
	logic fail_next = 1'b0;
	logic busy, done, refused, fail, ctrl_ready, cache_ready, wr_ready, rd_valid;
	logic ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb;
	logic [7:0] status, io_out, io, rd_data;
	int miscompares = 0;
	int n_compared = 0;
	nand_host i_dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_start(start), .i_req(req), .o_busy(busy),
		.o_done(done), .o_refused(refused), .o_fail(fail), .o_status(status), .o_ctrl_ready(ctrl_ready),
		.o_cache_ready(cache_ready), .i_wr_valid(wr_valid), .i_wr_data(wr_data), .o_wr_ready(wr_ready),
		.o_rd_valid(rd_valid), .o_rd_data(rd_data), .i_rd_ready(rd_ready), .o_ce_n(ce_n), .o_cle(cle),
		.o_ale(ale), .o_we_n(we_n), .o_re_n(re_n), .o_wp_n(wp_n), .o_io_out(io_out), .o_io_oe(io_oe),
		.i_io_in(io), .i_ready_busy(rb));
	nand_dev_model i_dev (.i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n),
		.i_wp_n(wp_n), .i_io_out(io_out), .i_io_oe(io_oe), .i_fail_next(fail_next), .o_io(io),
		.o_ready_busy(rb));
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic report_and_stop();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	function automatic logic [7:0] expect_byte(input logic [11:0] c);
		return (c < 12'h004) ? 8'h30 + c[7:0] : 8'hFF;
	endfunction : expect_byte
	task automatic do_op(input row_t r, input int hold, output logic refd, output int nr);
		int w;
		int t;
		logic fin;
		w = 0;
		nr = 0;
		refd = 1'b0;
		fin = 1'b0;
		t = 0;
		while (busy !== 1'b0 && t < 100) begin
			@(posedge ref_clk);
			#1;
			t++;
		end
		req = {r.op, r.addr, r.len};
		start = 1'b1;
		@(posedge ref_clk);
		#1;
		start = 1'b0;
		for (t = 0; t < 5000 && !(fin && rd_valid !== 1'b1); t++) begin
			wr_valid = (r.op == OP_PROG_LOAD || r.op == OP_RAND_IN || r.op == OP_COPY_LOAD) && w < r.len;
			wr_data = 8'h30 + r.addr[7:0] + w[7:0];
			rd_ready = t >= hold;
			@(posedge ref_clk);
			if (refused === 1'b1) refd = 1'b1;
			if (done === 1'b1 || refused === 1'b1) fin = 1'b1;
			if (t == hold - 1) check("busy with full fifo", 8'h01, {7'h0, busy});
			if (wr_valid && wr_ready === 1'b1) w++;
			if (rd_ready && rd_valid === 1'b1 && r.op inside {OP_READ, OP_CACHE_READ, OP_RAND_OUT}) begin
				check("read byte", expect_byte(r.addr[11:0] + nr[11:0]), rd_data);
				nr++;
			end
			#1;
		end
		wr_valid = 1'b0;
		check("op finished", 8'h01, {7'h0, fin});
	endtask : do_op
	initial begin
		logic rf;
		int nr;
		rows = '{'{OP_PROG_LOAD, ROW_A, 12'h004, 1'b0}, '{OP_PROG_GO, ROW_A, 12'h000, 1'b0},
			'{OP_PROG_LOAD, ROW_A, 12'h004, 1'b0}, '{OP_PROG_GO, ROW_A, 12'h000, 1'b0},
			'{OP_PROG_LOAD, ROW_A, 12'h004, 1'b0}, '{OP_PROG_GO, ROW_A, 12'h000, 1'b0},
			'{OP_PROG_LOAD, ROW_A, 12'h004, 1'b0}, '{OP_PROG_GO, ROW_A, 12'h000, 1'b0},
			'{OP_PROG_LOAD, ROW_A, 12'h004, 1'b1}, '{OP_PROG_GO, ROW_A, 12'h000, 1'b1},
			'{OP_READ, ROW_A, 12'h004, 1'b0}, '{OP_RAND_OUT, ROW_A + 2, 12'h002, 1'b0},
			'{OP_RAND_OUT, ROW_A + 1, 12'h001, 1'b0}, '{OP_PROG_LOAD, ROW_C, 12'h000, 1'b1},
			'{OP_PROG_LOAD, ROW_C, 12'h841, 1'b1}, '{OP_CACHE_READ, ROW_A + 5, 12'h004, 1'b1},
			'{OP_CACHE_READ, ROW_A, 12'h004, 1'b0}, '{OP_RAND_OUT, ROW_A + 2, 12'h002, 1'b1},
			'{OP_CACHE_EXIT, ROW_A, 12'h000, 1'b0}, '{OP_RAND_OUT, ROW_A + 2, 12'h002, 1'b1},
			'{OP_COPY_LOAD, ROW_C, 12'h000, 1'b1}, '{OP_COPY_READ, ROW_A, 12'h000, 1'b0},
			'{OP_COPY_LOAD, ROW_B, 12'h000, 1'b1}, '{OP_COPY_READ, ROW_A, 12'h000, 1'b0},
			'{OP_COPY_LOAD, ROW_C, 12'h000, 1'b0}, '{OP_PROG_GO, ROW_C, 12'h000, 1'b0},
			'{OP_READ, ROW_C, 12'h004, 1'b0}, '{OP_STATUS, ROW_C, 12'h000, 1'b0},
			'{OP_PROG_LOAD, ROW_D, 12'h001, 1'b0}, '{OP_RAND_IN, ROW_D + 29'h3, 12'h001, 1'b0},
			'{OP_RAND_IN, ROW_D + 29'h1, 12'h002, 1'b0}, '{OP_PROG_GO, ROW_D, 12'h000, 1'b0},
			'{OP_READ, ROW_D, 12'h004, 1'b0}, '{OP_RAND_IN, ROW_D, 12'h001, 1'b1}};
		repeat (3) @(posedge ref_clk);
		#1;
		check("ce_n in reset", 8'h01, {7'h0, ce_n});
		check("wp_n in reset", 8'h00, {7'h0, wp_n});
		rst = 1'b0;
		for (int i = 0; i < 34; i++) begin
			do_op(rows[i], 0, rf, nr);
			check("refused", {7'h0, rows[i].refused}, {7'h0, rf});
			check("bytes read", (rows[i].op inside {OP_READ, OP_CACHE_READ, OP_RAND_OUT} && !rows[i].refused) ?
				rows[i].len[7:0] : 8'h00, nr[7:0]);
			if (rows[i].op == OP_PROG_GO && !rows[i].refused) check("ready no fail", 8'h01, {6'h0, fail, ctrl_ready});
		end
		do_op('{OP_READ, ROW_A, 12'h028, 1'b0}, 600, rf, nr);
		check("bytes after stall", 8'h28, nr[7:0]);
		fail_next = 1'b1;
		do_op('{OP_PROG_LOAD, ROW_C, 12'h001, 1'b0}, 0, rf, nr);
		do_op('{OP_PROG_GO, ROW_C, 12'h000, 1'b0}, 0, rf, nr);
		check("fail flag", 8'h01, {7'h0, fail});
		check("status byte", 8'hE1, status);
		check("cache ready bit", 8'h01, {7'h0, cache_ready});
		// reset in the middle of an address cycle, then a clean read
		req = {OP_READ, ROW_A, 12'h004};
		start = 1'b1;
		@(posedge ref_clk);
		#1;
		start = 1'b0;
		repeat (10) @(posedge ref_clk);
		#1;
		rst = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		check("busy mid reset", 8'h00, {7'h0, busy});
		check("we_n mid reset", 8'h01, {7'h0, we_n});
		check("wp_n mid reset", 8'h00, {7'h0, wp_n});
		rst = 1'b0;
		do_op('{OP_READ, ROW_A, 12'h004, 1'b0}, 0, rf, nr);
		check("refused after reset", 8'h00, {7'h0, rf});
		check("bytes after reset", 8'h04, nr[7:0]);
		report_and_stop();
	end
	initial begin
		#600000;
		miscompares++;
		report_and_stop();
	end
endmodule : nand_host_tb_top
